// file: tb/dpc_link_monitor.sv
// Checker of the pins between the two link ends
`timescale 1ns/1ps
module dpc_link_monitor (
	// System
	input wire logic        clk_sys,
	input wire logic        rst,
	// Link pins
	input wire logic        tick_t,
	input wire logic        tick_gate,
	input wire logic        device_select_n,
	input wire logic        row_strobe_n,
	input wire logic        column_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic [1:0]  array_group_sel,
	input wire logic [12:0] addr_bus,
	input wire logic [1:0]  dq_mem_oe,
	input wire logic [1:0]  dq_ctl_oe,
	input wire logic [15:0] dq_ctl_o,
	input wire logic [1:0]  dqs_ctl_o
);
	// *****************
	// Pin checks
	// *****************
	wire logic [17:0] cw;
	// Strobes, group and address seen as one command word
	assign cw = {row_strobe_n, column_strobe_n, write_strobe_n,
		array_group_sel, addr_bus};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_issue;
		$fell(device_select_n);
	endsequence
	sequence s_held;
		$stable(cw) [*6];
	endsequence
	a_cmd_hold: assert property (s_issue |=> s_held)
		else $error("command pins moved");
	a_cmd_phase: assert property (s_issue |-> !tick_t)
		else $error("command not set up before tick rise");
	a_cmd_gap: assert property ($rose(device_select_n)
		|=> device_select_n [*6]) else $error("commands too close");
	// Self refresh entry drops the gate with its command
	a_cmd_gate: assert property (!device_select_n
		&& cw[17:15] != 3'b001 |-> tick_gate) else $error("cmd gate low");
	a_one_driver: assert property (!(|dq_mem_oe && |dq_ctl_oe))
		else $error("both ends drive data");
	a_wr_gate: assert property (|dq_ctl_oe |-> tick_gate)
		else $error("write with gate low");
	a_mem_off: assert property (!tick_gate [*4] |-> dq_mem_oe == 2'b00)
		else $error("memory drives with gate low");
	a_wr_centre: assert property (|dq_ctl_oe && $changed(dqs_ctl_o)
		|-> $stable(dq_ctl_o)) else $error("write strobe not centred");
endmodule

// file: tb/testbench.sv
// Self-checking bench joining both ends of the link
`timescale 1ns/1ps
`include "dpc_defines.svh"
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
	import dpc_pkg::*;
	// *****************
	// Signals
	// *****************
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv, r, s = 32'h1c;
	logic        pready, pslverr, se, wr_beat_valid;
	logic [15:0] rd_data = 16'h0, wr_beat_data, mk;
	logic [1:0]  wr_beat_keep, b;
	logic [3:0]  bank_open;
	logic [12:0] mode_word, cmd_addr;
	logic [17:0] e, eq[$];
	dpc_cmd_t    cmd_code;
	dpc_pwr_t    power_state;
	int          err_total = 0, checks = 0, wb = 0;
	dpc_link_if lnk ();
	dpc_mem_end dpc_mem_end_inst (.lnk, .clk_sys, .rst, .cmd_seen(),
		.cmd_code, .cmd_bank(), .cmd_addr, .bank_open, .power_state,
		.mode_word, .ext_word(), .wr_beat_valid, .wr_beat_data,
		.wr_beat_keep, .rd_beat(), .rd_data);
	dpc_ctl_end dpc_ctl_end_inst (.lnk, .clk_sys, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	dpc_link_monitor dpc_link_monitor_inst (.clk_sys, .rst,
		.tick_t(lnk.tick_t), .tick_gate(lnk.tick_gate),
		.device_select_n(lnk.device_select_n),
		.row_strobe_n(lnk.row_strobe_n),
		.column_strobe_n(lnk.column_strobe_n),
		.write_strobe_n(lnk.write_strobe_n),
		.array_group_sel(lnk.array_group_sel), .addr_bus(lnk.addr_bus),
		.dq_mem_oe(lnk.dq_mem_oe), .dq_ctl_oe(lnk.dq_ctl_oe),
		.dq_ctl_o(lnk.dq_ctl_o), .dqs_ctl_o(lnk.dqs_ctl_o));
	always #5 clk_sys = ~clk_sys;
	// Repeatable pseudo-random source
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// One APB transfer; the request holds until pready is sampled
	task automatic ap(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rv = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Command, then poll busy so later checks see its effect
	task automatic cmd(input logic [31:0] w);
		ap(1'b1, `DPC_OFS_CMD, w);
		do begin
			ap(1'b0, `DPC_OFS_STATUS, 32'h0);
		end while (rv[0] !== 1'b0);
	endtask
	// Set the gate and wait a bounded time for the power state
	task automatic pw(input logic [31:0] c, input dpc_pwr_t x);
		int n = 0;
		ap(1'b1, `DPC_OFS_CTRL, c);
		while (power_state !== x && n < 99) begin
			@(posedge clk_sys);
			n++;
		end
		`CK("power_state", x, power_state)
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Write beats against the model queue; masked lanes ignore data
	always @(posedge clk_sys) begin
		if (!rst && wr_beat_valid === 1'b1) begin
			wb++;
			e = eq.size() ? eq.pop_front() : 18'h0;
			mk = {{8{e[17]}}, {8{e[16]}}};
			`CK("keep", e[17:16], wr_beat_keep)
			`CK("data", e[15:0] & mk, wr_beat_data & mk)
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		`CK("dq_mem_oe", 2'b00, lnk.dq_mem_oe)
		ap(1'b0, 12'h020, 32'h0);
		`CK("unmapped", 1'b1, se)
		ap(1'b1, `DPC_OFS_CMD, 32'h7);
		`CK("gate low cmd", 1'b1, se)
		pw(32'h5, PWR_RUN);
		cmd(32'h40);
		`CK("mode_word", 13'h001, mode_word)
		r = xs();
		b = r[14:13];
		cmd({r[12:0], b, 4'h3});
		`CK("cmd_code", CMD_ACT, cmd_code)
		`CK("cmd_addr", r[12:0], cmd_addr)
		`CK("bank_open", 4'h1 << b, bank_open)
		$display("end of test activate");
		r = xs();
		ap(1'b1, `DPC_OFS_WDATA, {14'h0, r[17:0]});
		repeat (2) eq.push_back({~r[17:16], r[15:0]});
		cmd({13'h0, b, 4'h4});
		`CK("write beats", 2, wb)
		$display("end of test write");
		r = xs();
		rd_data <= r[15:0];
		cmd({13'h0, b, 4'h5});
		ap(1'b0, `DPC_OFS_RDATA, 32'h0);
		`CK("read word", {4'h2, r[15:0]}, rv[19:0])
		$display("end of test read");
		cmd({13'h0, b + 2'd1, 4'h3});
		cmd({13'h0, b, 4'h2});
		`CK("bank_open", 4'h1 << (b + 2'd1), bank_open)
		pw(32'h4, PWR_PD_ACT);
		pw(32'h5, PWR_RUN);
		cmd(32'h10002);
		`CK("bank_open", 4'h0, bank_open)
		pw(32'h4, PWR_PD_PRE);
		pw(32'h5, PWR_RUN);
		cmd(32'h9);
		`CK("power_state", PWR_SELF, power_state)
		pw(32'h5, PWR_RUN);
		$display("end of test power");
		finish_test();
	end
	// Watchdog against a hung handshake
	initial begin
		#500000;
		err_total++;
		finish_test();
	end
endmodule

// file: verilog/dpc_ctl_end.sv
// Controller end of the DDR pin command link with its APB registers
`timescale 1ns/1ps
`include "dpc_defines.svh"
module dpc_ctl_end (
	// Link pins
	dpc_link_if.ctl           lnk,
	// System
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr
);
	import dpc_pkg::*;

	// ****************************************
	// Tick divider
	// ****************************************
	logic [2:0] ph_r;
	logic       half_start;
	logic       mid_half;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ph_r <= 3'h0;
		end else begin
			ph_r <= ph_r + 3'h1;
		end
	end
	assign half_start = ph_r == 3'h0 || ph_r == `DPC_TICK_HALF;
	assign mid_half   = ph_r == `DPC_TICK_QUART
		|| ph_r == `DPC_TICK_HALF + `DPC_TICK_QUART;
	assign lnk.tick_t = ph_r < `DPC_TICK_HALF;
	assign lnk.tick_c = ph_r >= `DPC_TICK_HALF;

	// ****************************************
	// APB decode and registers
	// ****************************************
	dpc_cst_t    st_r;
	logic [4:0]  ctrl_r;
	logic [18:0] cmd_r;
	logic [17:0] wdat_r;
	logic [15:0] rdat_r;
	logic [3:0]  rcnt_r;
	logic        gate_r;
	logic        acc;
	logic        hit;
	logic        cmd_ok;

	assign acc    = psel & penable;
	assign hit    = paddr == `DPC_OFS_CTRL || paddr == `DPC_OFS_CMD
		|| paddr == `DPC_OFS_WDATA || paddr == `DPC_OFS_RDATA
		|| paddr == `DPC_OFS_STATUS;
	// A command write waits while a transfer is still running
	assign pready  = !(pwrite && paddr == `DPC_OFS_CMD
		&& st_r != CS_IDLE);
	assign cmd_ok  = gate_r;
	assign pslverr = acc & (!hit || (pwrite && paddr == `DPC_OFS_CMD
		&& !cmd_ok));

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			case (paddr)
				`DPC_OFS_CTRL:   prdata <= {27'h0, ctrl_r};
				`DPC_OFS_CMD:    prdata <= {13'h0, cmd_r};
				`DPC_OFS_WDATA:  prdata <= {14'h0, wdat_r};
				`DPC_OFS_RDATA:  prdata <= {12'h0, rcnt_r, rdat_r};
				`DPC_OFS_STATUS: prdata <= {30'h0, gate_r,
					st_r != CS_IDLE};
				default:         prdata <= 32'h0;
			endcase
		end
	end

	logic wr_ctrl;
	logic wr_cmd;
	logic self_cmd;

	assign wr_ctrl  = acc & pwrite & pready & paddr == `DPC_OFS_CTRL;
	assign wr_cmd   = acc & pwrite & pready & paddr == `DPC_OFS_CMD
		& cmd_ok;
	assign self_cmd = cmd_r[`DPC_CMD_SELF_BIT];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_r <= `DPC_CTRL_RST;
			wdat_r <= 18'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= pwdata[4:0];
			end else if (st_r == CS_ARM && ph_r == `DPC_TICK_HALF
				&& self_cmd) begin
				ctrl_r[0] <= 1'b0;
			end
			if (acc && pwrite && paddr == `DPC_OFS_WDATA) begin
				wdat_r <= pwdata[17:0];
			end
		end
	end

	// ****************************************
	// Command and data sequencer
	// ****************************************
	logic [3:0]  beats_r;
	logic [3:0]  bl;
	logic [1:0]  rs1_r;
	logic [1:0]  rs2_r;
	logic        rprev_r;
	logic [15:0] rd1_r;
	logic [15:0] rd2_r;
	logic        r_edge;
	dpc_cmd_t    cmd_kind;

	assign bl       = dpc_beats(ctrl_r[4:2]);
	assign cmd_kind = dpc_decode(1'b0, cmd_r[2:0]);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r                <= CS_IDLE;
			cmd_r               <= 19'h7;
			gate_r              <= 1'b0;
			beats_r             <= 4'h0;
			lnk.device_select_n <= 1'b1;
			lnk.row_strobe_n    <= 1'b1;
			lnk.column_strobe_n <= 1'b1;
			lnk.write_strobe_n  <= 1'b1;
			lnk.array_group_sel <= 2'h0;
			lnk.addr_bus        <= 13'h0;
		end else begin
			case (st_r)
				CS_IDLE: begin
					gate_r <= ctrl_r[0];
					if (wr_cmd) begin
						cmd_r <= pwdata[18:0];
						st_r  <= CS_ARM;
					end
				end
				CS_ARM: begin
					// Pins change one cycle into the low phase, stable at the rise
					if (ph_r == `DPC_TICK_HALF) begin
						lnk.device_select_n <= 1'b0;
						{lnk.row_strobe_n, lnk.column_strobe_n,
							lnk.write_strobe_n} <= cmd_r[2:0];
						lnk.array_group_sel <= cmd_r[5:4];
						lnk.addr_bus        <= cmd_r[18:6];
						gate_r              <= !self_cmd;
						st_r                <= CS_HOLD;
					end
				end
				CS_HOLD: begin
					if (ph_r == `DPC_TICK_HALF) begin
						lnk.device_select_n <= 1'b1;
						{lnk.row_strobe_n, lnk.column_strobe_n,
							lnk.write_strobe_n} <= 3'h7;
						beats_r <= bl;
						if (cmd_kind == CMD_WR) begin
							st_r <= CS_WDAT;
						end else if (cmd_kind == CMD_RD) begin
							st_r <= CS_RDAT;
						end else begin
							st_r <= CS_IDLE;
						end
					end
				end
				CS_WDAT: begin
					if (half_start && beats_r == 4'h0) begin
						st_r <= CS_IDLE;
					end else if (mid_half && beats_r != 4'h0) begin
						beats_r <= beats_r - 4'h1;
					end
				end
				CS_RDAT: begin
					if (r_edge) begin
						beats_r <= beats_r - 4'h1;
						if (beats_r == 4'h1) begin
							st_r <= CS_IDLE;
						end
					end
				end
				default: st_r <= CS_IDLE;
			endcase
		end
	end
	assign lnk.tick_gate = gate_r;

	// ****************************************
	// Write data and centred strobe
	// ****************************************
	logic        woe_r;
	logic        wdqs_r;
	logic [15:0] wdq_r;
	logic [1:0]  wmask_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			woe_r   <= 1'b0;
			wdqs_r  <= 1'b0;
			wdq_r   <= 16'h0;
			wmask_r <= 2'h0;
		end else if (st_r == CS_HOLD && ph_r == `DPC_TICK_HALF) begin
			// Data must settle before the first strobe toggle
			woe_r   <= cmd_kind == CMD_WR;
			wdqs_r  <= 1'b0;
			wdq_r   <= wdat_r[15:0];
			wmask_r <= wdat_r[17:16];
		end else if (st_r == CS_WDAT && half_start) begin
			woe_r   <= beats_r != 4'h0;
			wdq_r   <= wdat_r[15:0];
			wmask_r <= wdat_r[17:16];
		end else if (st_r == CS_WDAT && mid_half && beats_r != 4'h0) begin
			wdqs_r <= ~wdqs_r;
		end
	end

	assign lnk.dq_ctl_o         = wdq_r;
	assign lnk.dq_ctl_oe        = {2{woe_r}};
	assign lnk.dqs_ctl_o        = {2{wdqs_r}};
	assign lnk.dqs_ctl_oe       = {2{woe_r}};
	assign lnk.dqs_c_ctl_o      = {2{~wdqs_r}};
	assign lnk.dqs_c_ctl_oe     = {2{woe_r & ctrl_r[1]}};
	assign lnk.lower_write_mask = wmask_r[0];
	assign lnk.upper_write_mask = wmask_r[1];

	// ****************************************
	// Read capture on strobe edges
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rs1_r   <= 2'h0;
			rs2_r   <= 2'h0;
			rd1_r   <= 16'h0;
			rd2_r   <= 16'h0;
			rprev_r <= 1'b0;
		end else begin
			rs1_r   <= lnk.dqs;
			rs2_r   <= rs1_r;
			rd1_r   <= lnk.dq;
			rd2_r   <= rd1_r;
			rprev_r <= rs2_r[0];
		end
	end
	assign r_edge = st_r == CS_RDAT && (rs2_r[0] ^ rprev_r);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdat_r <= 16'h0;
			rcnt_r <= 4'h0;
		end else if (st_r == CS_HOLD) begin
			rcnt_r <= 4'h0;
		end else if (r_edge) begin
			rdat_r <= rd2_r;
			rcnt_r <= rcnt_r + 4'h1;
		end
	end
endmodule

// file: verilog/dpc_defines.svh
// Constants for the DDR pin command link: timing, fields and offsets
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
// ****************************************
// Link timing in system clock cycles, read latency in ticks
// ****************************************
`define DPC_TICK_HALF     3'd4
`define DPC_TICK_QUART    3'd2
`define DPC_CL_TICKS      2'd2
// ****************************************
// Address and mode word fields
// ****************************************
`define DPC_PRE_ALL_BIT   10
`define DPC_MR_BL_LSB     0
`define DPC_EMR_DIFF_BIT  10
`define DPC_EMR_READ_STROBE_X8_BIT  11
`define DPC_SEL_MODE      2'd0
`define DPC_SEL_EXT       2'd1
// ****************************************
// Controller register offsets and fields
// ****************************************
`define DPC_OFS_CTRL      12'h000
`define DPC_OFS_CMD       12'h004
`define DPC_OFS_WDATA     12'h008
`define DPC_OFS_RDATA     12'h00c
`define DPC_OFS_STATUS    12'h010
`define DPC_CTRL_RST      5'h00
`define DPC_CMD_SELF_BIT  3
`endif

// file: verilog/dpc_link_if.sv
// Pin bundle between memory and controller, with bus resolution
`timescale 1ns/1ps
interface dpc_link_if;
	logic        tick_t;
	logic        tick_c;
	logic        tick_gate;
	logic        device_select_n;
	logic        row_strobe_n;
	logic        column_strobe_n;
	logic        write_strobe_n;
	logic [1:0]  array_group_sel;
	logic [12:0] addr_bus;
	logic        lower_write_mask;
	logic        upper_write_mask;
	logic [15:0] dq_mem_o;
	logic [1:0]  dq_mem_oe;
	logic [15:0] dq_ctl_o;
	logic [1:0]  dq_ctl_oe;
	logic [1:0]  dqs_mem_o;
	logic [1:0]  dqs_mem_oe;
	logic [1:0]  dqs_c_mem_o;
	logic [1:0]  dqs_c_mem_oe;
	logic [1:0]  dqs_ctl_o;
	logic [1:0]  dqs_ctl_oe;
	logic [1:0]  dqs_c_ctl_o;
	logic [1:0]  dqs_c_ctl_oe;
	logic [15:0] dq;
	logic [1:0]  dqs;
	logic [1:0]  dqs_c;

	// Wire level per lane; an undriven lane reads low
	assign dq[7:0]  = (dq_mem_o[7:0] & {8{dq_mem_oe[0]}})
		| (dq_ctl_o[7:0] & {8{dq_ctl_oe[0]}});
	assign dq[15:8] = (dq_mem_o[15:8] & {8{dq_mem_oe[1]}})
		| (dq_ctl_o[15:8] & {8{dq_ctl_oe[1]}});
	assign dqs   = (dqs_mem_o & dqs_mem_oe) | (dqs_ctl_o & dqs_ctl_oe);
	assign dqs_c = (dqs_c_mem_o & dqs_c_mem_oe)
		| (dqs_c_ctl_o & dqs_c_ctl_oe);

	modport mem (
		input  tick_t, tick_c, tick_gate, device_select_n, row_strobe_n,
		input  column_strobe_n, write_strobe_n, array_group_sel, addr_bus,
		input  lower_write_mask, upper_write_mask, dq, dqs, dqs_c,
		output dq_mem_o, dq_mem_oe, dqs_mem_o, dqs_mem_oe,
		output dqs_c_mem_o, dqs_c_mem_oe
	);
	modport ctl (
		output tick_t, tick_c, tick_gate, device_select_n, row_strobe_n,
		output column_strobe_n, write_strobe_n, array_group_sel, addr_bus,
		output lower_write_mask, upper_write_mask,
		output dq_ctl_o, dq_ctl_oe, dqs_ctl_o, dqs_ctl_oe,
		output dqs_c_ctl_o, dqs_c_ctl_oe,
		input  dq, dqs
	);
endinterface

// file: verilog/dpc_mem_end.sv
// Memory end of the DDR pin command link
`timescale 1ns/1ps
`include "dpc_defines.svh"
module dpc_mem_end #(
	parameter bit ORG_X8 = 1'b0
) (
	// Link pins
	dpc_link_if.mem               lnk,
	// System
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Command report
	output logic                  cmd_seen,
	output dpc_pkg::dpc_cmd_t     cmd_code,
	output logic [1:0]            cmd_bank,
	output logic [12:0]           cmd_addr,
	// State
	output logic [3:0]            bank_open,
	output dpc_pkg::dpc_pwr_t     power_state,
	output logic [12:0]           mode_word,
	output logic [12:0]           ext_word,
	// Write beats
	output logic                  wr_beat_valid,
	output logic [15:0]           wr_beat_data,
	output logic [1:0]            wr_beat_keep,
	// Read beats
	output logic                  rd_beat,
	input  wire logic [15:0]      rd_data
);
	import dpc_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [43:0] pin_raw;
	logic [43:0] s1_r;
	logic [43:0] s2_r;
	logic        tick_prev_r;
	logic [1:0]  dqs_prev_r;

	assign pin_raw = {lnk.tick_t, lnk.tick_c, lnk.tick_gate,
		lnk.device_select_n, lnk.row_strobe_n, lnk.column_strobe_n,
		lnk.write_strobe_n, lnk.array_group_sel, lnk.addr_bus,
		lnk.lower_write_mask, lnk.upper_write_mask, lnk.dq, lnk.dqs,
		lnk.dqs_c};

	// Every pin crosses two flops before use
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_r <= 44'h0;
			s2_r <= 44'h0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
		end
	end

	logic        tick_lvl;
	logic        gate_s;
	logic        sel_n_s;
	logic [2:0]  strb_s;
	logic [1:0]  grp_s;
	logic [12:0] addr_s;
	logic [1:0]  mask_s;
	logic [15:0] dq_s;
	logic [1:0]  dqs_s;
	logic [1:0]  dqs_c_s;

	assign tick_lvl = s2_r[43] & ~s2_r[42];
	assign gate_s   = s2_r[41];
	assign sel_n_s  = s2_r[40];
	assign strb_s   = s2_r[39:37];
	assign grp_s    = s2_r[36:35];
	assign addr_s   = s2_r[34:22];
	assign mask_s   = {s2_r[20], s2_r[21]};
	assign dq_s     = s2_r[19:4];
	assign dqs_s    = s2_r[3:2];
	assign dqs_c_s  = s2_r[1:0];

	// ****************************************
	// Edges of the tick and strobes
	// ****************************************
	dpc_pwr_t   pwr_r;
	logic [3:0] open_r;
	logic [12:0] mode_r;
	logic [12:0] ext_r;
	logic       diff_on;
	logic       tick_rise;
	logic       tick_fall;
	logic       tick_edge;
	logic [1:0] dqs_lvl;
	logic [1:0] dqs_edge;
	dpc_cmd_t   cmd_now;
	logic       cmd_take;

	assign diff_on   = ext_r[`DPC_EMR_DIFF_BIT];
	// Self refresh stops the internal tick altogether
	assign tick_rise = tick_lvl & ~tick_prev_r
		& (pwr_r != PWR_SELF);
	assign tick_fall = ~tick_lvl & tick_prev_r & (pwr_r != PWR_SELF);
	assign tick_edge = tick_rise | tick_fall;
	// Differential strobe counts only at a full crossing
	assign dqs_lvl   = diff_on ? (dqs_s & ~dqs_c_s) : dqs_s;
	assign dqs_edge  = (dqs_lvl ^ dqs_prev_r)
		& {2{pwr_r == PWR_RUN}};
	assign cmd_now   = dpc_decode(sel_n_s, strb_s);
	assign cmd_take  = tick_rise & gate_s & (pwr_r == PWR_RUN);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tick_prev_r <= 1'b0;
			dqs_prev_r  <= 2'h0;
		end else begin
			tick_prev_r <= tick_lvl;
			dqs_prev_r  <= dqs_lvl;
		end
	end

	// ****************************************
	// Power state
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwr_r <= PWR_RUN;
		end else begin
			case (pwr_r)
				PWR_RUN: begin
					if (tick_rise && !gate_s) begin
						if (open_r != 4'h0) begin
							pwr_r <= PWR_PD_ACT;
						end else if (cmd_now == CMD_REF) begin
							pwr_r <= PWR_SELF;
						end else begin
							pwr_r <= PWR_PD_PRE;
						end
					end
				end
				PWR_PD_PRE, PWR_PD_ACT: begin
					if (tick_rise && gate_s) begin
						pwr_r <= PWR_RUN;
					end
				end
				PWR_SELF: begin
					// Leaving needs no tick edge at all
					if (gate_s) begin
						pwr_r <= PWR_RUN;
					end
				end
				default: pwr_r <= PWR_RUN;
			endcase
		end
	end

	// ****************************************
	// Command report and mode words
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_seen <= 1'b0;
			cmd_code <= CMD_DESEL;
			cmd_bank <= 2'h0;
			cmd_addr <= 13'h0;
		end else begin
			cmd_seen <= cmd_take && cmd_now != CMD_DESEL;
			if (cmd_take) begin
				cmd_code <= cmd_now;
				cmd_bank <= grp_s;
				cmd_addr <= addr_s;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r <= 13'h0;
			ext_r  <= 13'h0;
		end else if (cmd_take && cmd_now == CMD_MODE) begin
			if (grp_s == `DPC_SEL_MODE) begin
				mode_r <= addr_s;
			end else if (grp_s == `DPC_SEL_EXT) begin
				ext_r <= addr_s;
			end
		end
	end

	// ****************************************
	// Bank rows and auto precharge
	// ****************************************
	logic [3:0] rd_left_r;
	logic [3:0] wr_left_r;
	logic       ap_pend_r;
	logic [1:0] ap_bank_r;
	logic       ap_hit;

	assign ap_hit = addr_s[`DPC_PRE_ALL_BIT];
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			open_r    <= 4'h0;
			ap_pend_r <= 1'b0;
			ap_bank_r <= 2'h0;
		end else if (cmd_take && cmd_now == CMD_ACT) begin
			open_r[grp_s] <= 1'b1;
		end else if (cmd_take && cmd_now == CMD_PRE) begin
			if (ap_hit) begin
				open_r <= 4'h0;
			end else begin
				open_r[grp_s] <= 1'b0;
			end
		end else if (cmd_take && (cmd_now == CMD_RD
			|| cmd_now == CMD_WR)) begin
			ap_pend_r <= ap_hit;
			ap_bank_r <= grp_s;
		end else if (ap_pend_r && rd_left_r == 4'h0
			&& wr_left_r == 4'h0) begin
			// Row closes once its burst has finished
			open_r[ap_bank_r] <= 1'b0;
			ap_pend_r         <= 1'b0;
		end
	end

	// ****************************************
	// Read burst driver
	// ****************************************
	logic [1:0]  rd_wait_r;
	logic        oe_r;
	logic        dqs_o_r;
	logic [15:0] dq_o_r;
	logic        beat_now;

	// First beat leaves on the rise that ends the latency
	assign beat_now = tick_edge && rd_left_r != 4'h0
		&& (rd_wait_r == 2'h0 || (rd_wait_r == 2'h1 && tick_rise));
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_wait_r <= 2'h0;
			rd_left_r <= 4'h0;
			oe_r      <= 1'b0;
			dqs_o_r   <= 1'b0;
			dq_o_r    <= 16'h0;
			rd_beat   <= 1'b0;
		end else begin
			rd_beat <= beat_now;
			if (cmd_take && cmd_now == CMD_RD) begin
				rd_wait_r <= `DPC_CL_TICKS;
				rd_left_r <= dpc_beats(mode_r[`DPC_MR_BL_LSB +: 3]);
			end else if (beat_now) begin
				dq_o_r    <= rd_data;
				dqs_o_r   <= ~dqs_o_r;
				oe_r      <= gate_s;
				rd_left_r <= rd_left_r - 4'h1;
				rd_wait_r <= 2'h0;
			end else if (tick_rise && rd_wait_r != 2'h0) begin
				rd_wait_r <= rd_wait_r - 2'h1;
			end else if (tick_edge || !gate_s) begin
				oe_r    <= 1'b0;
				dqs_o_r <= 1'b0;
			end
		end
	end

	assign lnk.dq_mem_o     = dq_o_r;
	assign lnk.dq_mem_oe    = {oe_r & ~ORG_X8, oe_r};
	assign lnk.dqs_mem_o    = {2{dqs_o_r}};
	assign lnk.dqs_mem_oe   = {oe_r & ~ORG_X8, oe_r};
	assign lnk.dqs_c_mem_o  = {2{~dqs_o_r}};
	assign lnk.dqs_c_mem_oe = {oe_r & ~ORG_X8, oe_r} & {2{diff_on}};

	// ****************************************
	// Write beat receiver
	// ****************************************
	logic [1:0] lane_on;
	logic [1:0] lane_edge;
	logic [1:0] mask_use;

	assign lane_on   = ORG_X8 ? 2'h1 : 2'h3;
	assign lane_edge = dqs_edge & lane_on & {2{wr_left_r != 4'h0}};
	// Eight-bit part drops masking when the read strobe is on
	assign mask_use  = (ORG_X8 && ext_r[`DPC_EMR_READ_STROBE_X8_BIT])
		? 2'h0 : mask_s;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_left_r     <= 4'h0;
			wr_beat_valid <= 1'b0;
			wr_beat_data  <= 16'h0;
			wr_beat_keep  <= 2'h0;
		end else begin
			wr_beat_valid <= lane_edge != 2'h0;
			if (cmd_take && cmd_now == CMD_WR) begin
				wr_left_r <= dpc_beats(mode_r[`DPC_MR_BL_LSB +: 3]);
			end else if (lane_edge[0]) begin
				wr_left_r <= wr_left_r - 4'h1;
			end
			if (lane_edge != 2'h0) begin
				wr_beat_data <= dq_s;
				wr_beat_keep <= lane_edge & ~mask_use;
			end
		end
	end

	assign bank_open   = open_r;
	assign power_state = pwr_r;
	assign mode_word   = mode_r;
	assign ext_word    = ext_r;
endmodule

// file: verilog/dpc_pkg.sv
// Types and shared decode helpers for the DDR pin command link
package dpc_pkg;
	// Order follows {row, column, write} strobe levels
	typedef enum logic [3:0] {
		CMD_MODE, CMD_REF, CMD_PRE, CMD_ACT,
		CMD_WR, CMD_RD, CMD_STOP, CMD_NOP, CMD_DESEL
	} dpc_cmd_t;
	typedef enum logic [1:0] {
		PWR_RUN, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF
	} dpc_pwr_t;
	typedef enum logic [2:0] {
		CS_IDLE, CS_ARM, CS_HOLD, CS_WDAT, CS_RDAT
	} dpc_cst_t;

	// Command from select and strobe levels
	function automatic dpc_cmd_t dpc_decode(input logic sel_n,
		input logic [2:0] strb_n);
		if (sel_n) begin
			return CMD_DESEL;
		end
		return dpc_cmd_t'({1'b0, strb_n});
	endfunction

	// Beats per burst from the burst length field
	function automatic logic [3:0] dpc_beats(input logic [2:0] f);
		case (f)
			3'h2: return 4'h4;
			3'h3: return 4'h8;
			default: return 4'h2;
		endcase
	endfunction
endpackage
